// ===== src/adc_seq_cfg_pkg.sv
/*
 converter sequencing configuration: register indices, field positions,
 reset values and decode constants.
 assumes a classic wishbone slave with 32-bit data, one register per word.
*/
package adc_seq_cfg_pkg;
   // register indices; byte address is four times the index
   localparam logic [3:0] IDX_WRAP = 4'h0;
   localparam logic [3:0] IDX_TRIG = 4'h1;
   localparam logic [3:0] IDX_STATUS = 4'h2;
   localparam logic [3:0] IDX_CMD = 4'h3;
   localparam int ADDR_LSB = 2;
   localparam int ADDR_W = 4;

   // wrap register fields
   localparam int WRAP_RSV_BIT = 7;
   localparam int WRAP_MSB = 3;
   localparam int WRAP_LSB = 0;
   localparam logic [7:0] WRAP_RMASK = 8'h0f;

   // resolution / trigger register fields
   localparam int TSEL_BIT = 7;
   localparam int RES_MSB = 6;
   localparam int RES_LSB = 5;
   localparam int DIS_BIT = 4;
   localparam int TCH_MSB = 3;
   localparam int TCH_LSB = 0;

   localparam logic [7:0] WRAP_RESET = 8'h0f;
   localparam logic [7:0] TRIG_RESET = 8'h2f;

   // resolution codes
   localparam logic [1:0] RES_8 = 2'h0;
   localparam logic [1:0] RES_10 = 2'h1;
   localparam logic [1:0] RES_12 = 2'h2;
   localparam logic [1:0] RES_RSV = 2'h3;

   localparam logic [2:0] LAST_INPUT = 3'h7;
   localparam logic [3:0] DED_LIMIT = 4'h4;
   localparam logic [3:0] DIS_EXTRA = 4'h2;

   // command register bits
   localparam int CMD_START_BIT = 0;
   localparam int CMD_MULTI_CHANNEL_MODE_BIT = 1;
endpackage

// ===== src/adc_seq_cfg.sv
/*
 configuration and sequence-abort logic for an 8-input, 12-bit converter.
 holds the wrap and resolution/trigger registers, decodes them for the
 sequencer and tracks a running sequence, aborted by any write to either with sel_i[0] set.
 assumes a classic wishbone master on clk_i; conversion engine outside
 reports each finished conversion with conv_done_i.
*/
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps

module adc_seq_cfg #(
   parameter bit DED_TRIG_PRESENT = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [5:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic err_o,
   input wire logic conv_done_i,
   output logic busy_o,
   output logic abort_o,
   output logic [2:0] conv_channel_o,
   output logic [2:0] wrap_input_o,
   output logic wrap_reserved_o,
   output logic [1:0] resolution_select_o,
   output logic resolution_reserved_o,
   output logic discharge_before_sample_o,
   output logic [3:0] sample_extra_o,
   output logic trig_dedicated_o,
   output logic [2:0] trig_analog_o,
   output logic [1:0] trig_dedicated_sel_o,
   output logic trig_reserved_o
);

   logic [7:0] wrap_q;
   logic [7:0] trig_q;
   logic multi_channel_mode_q;
   logic busy_q;
   logic [2:0] chan_q;
   logic [31:0] dat_q;
   logic ack_q;
   logic err_q;
   logic abort_q;
   logic [3:0] idx;
   logic req;
   logic wr;
   logic hit;
   logic wr_wrap;
   logic wr_trig;
   logic wr_cmd;
   logic [3:0] wcode;
   logic [3:0] tcode;
   logic [1:0] res;
   logic [2:0] wrap_in;

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   assign idx = adr_i[adc_seq_cfg_pkg::ADDR_LSB +: adc_seq_cfg_pkg::ADDR_W];
   assign req = cyc_i && stb_i && !ack_q && !err_q;
   assign hit = (idx == adc_seq_cfg_pkg::IDX_WRAP)
      || (idx == adc_seq_cfg_pkg::IDX_TRIG)
      || (idx == adc_seq_cfg_pkg::IDX_STATUS)
      || (idx == adc_seq_cfg_pkg::IDX_CMD);
   assign wr = req && we_i && sel_i[0];
   assign wr_wrap = wr && (idx == adc_seq_cfg_pkg::IDX_WRAP);
   assign wr_trig = wr && (idx == adc_seq_cfg_pkg::IDX_TRIG);
   assign wr_cmd = wr && (idx == adc_seq_cfg_pkg::IDX_CMD);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
      end
      else
      begin
         ack_q <= req && hit;
         err_q <= req && !hit;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_q <= 32'h0;
      else if (req && !we_i)
      begin
         case (idx)
            adc_seq_cfg_pkg::IDX_WRAP:
               dat_q <= {24'h0, wrap_q & adc_seq_cfg_pkg::WRAP_RMASK};
            adc_seq_cfg_pkg::IDX_TRIG:
               dat_q <= {24'h0, trig_q};
            adc_seq_cfg_pkg::IDX_STATUS:
               dat_q <= {28'h0, chan_q, busy_q};
            adc_seq_cfg_pkg::IDX_CMD:
               dat_q <= {30'h0, multi_channel_mode_q, 1'b0};
            default:
               dat_q <= 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers; bit 7 of wrap stored, reads zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wrap_q <= adc_seq_cfg_pkg::WRAP_RESET;
      else if (wr_wrap)
         wrap_q <= dat_i[7:0];
   end

   // selector stored even without dedicated inputs
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         trig_q <= adc_seq_cfg_pkg::TRIG_RESET;
      else if (wr_trig)
         trig_q <= dat_i[7:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         multi_channel_mode_q <= 1'b0;
      else if (wr_cmd)
         multi_channel_mode_q <= dat_i[adc_seq_cfg_pkg::CMD_MULTI_CHANNEL_MODE_BIT];
   end

   ////////////////////////////////////////////////////////////////////////
   // field decode
   assign wcode = wrap_q[adc_seq_cfg_pkg::WRAP_MSB:adc_seq_cfg_pkg::WRAP_LSB];
   assign tcode = trig_q[adc_seq_cfg_pkg::TCH_MSB:adc_seq_cfg_pkg::TCH_LSB];
   assign res = trig_q[adc_seq_cfg_pkg::RES_MSB:adc_seq_cfg_pkg::RES_LSB];
   // codes 8-15 saturate at the last input
   assign wrap_in = wcode[3] ? adc_seq_cfg_pkg::LAST_INPUT : wcode[2:0];

   ////////////////////////////////////////////////////////////////////////
   // sequence tracking
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy_q <= 1'b0;
         chan_q <= 3'h0;
      end
      else if (wr_wrap || wr_trig)
      begin
         busy_q <= 1'b0;
         chan_q <= 3'h0;
      end
      else if (wr_cmd && dat_i[adc_seq_cfg_pkg::CMD_START_BIT])
      begin
         busy_q <= 1'b1;
         chan_q <= 3'h0;
      end
      else if (busy_q && conv_done_i)
      begin
         // wrap back to input 0 after the selected last input
         if (multi_channel_mode_q && chan_q != wrap_in && wcode != 4'h0)
            chan_q <= chan_q + 3'h1;
         else
            chan_q <= 3'h0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         abort_q <= 1'b0;
      else
         abort_q <= (wr_wrap || wr_trig) && busy_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // registered decode outputs
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wrap_input_o <= 3'h0;
         wrap_reserved_o <= 1'b0;
         resolution_select_o <= adc_seq_cfg_pkg::RES_8;
         resolution_reserved_o <= 1'b0;
         discharge_before_sample_o <= 1'b0;
         sample_extra_o <= 4'h0;
      end
      else
      begin
         wrap_input_o <= wrap_in;
         wrap_reserved_o <= (wcode == 4'h0);
         resolution_select_o <= res;
         resolution_reserved_o <= (res == adc_seq_cfg_pkg::RES_RSV);
         discharge_before_sample_o <= trig_q[adc_seq_cfg_pkg::DIS_BIT];
         sample_extra_o <= trig_q[adc_seq_cfg_pkg::DIS_BIT]
            ? adc_seq_cfg_pkg::DIS_EXTRA : 4'h0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         trig_dedicated_o <= 1'b0;
         trig_analog_o <= 3'h0;
         trig_dedicated_sel_o <= 2'h0;
         trig_reserved_o <= 1'b0;
      end
      else
      begin
         // analog source, codes 8-15 saturate
         trig_analog_o <= tcode[3] ? adc_seq_cfg_pkg::LAST_INPUT
            : tcode[2:0];
         trig_dedicated_sel_o <= tcode[1:0];
         // selector ignored without dedicated inputs
         trig_dedicated_o <= trig_q[adc_seq_cfg_pkg::TSEL_BIT]
            && DED_TRIG_PRESENT;
         trig_reserved_o <= trig_q[adc_seq_cfg_pkg::TSEL_BIT]
            && DED_TRIG_PRESENT
            && (tcode >= adc_seq_cfg_pkg::DED_LIMIT);
      end
   end

   assign dat_o = dat_q;
   assign ack_o = ack_q;
   assign err_o = err_q;
   assign busy_o = busy_q;
   assign abort_o = abort_q;
   assign conv_channel_o = chan_q;
endmodule

// ===== testbench/adc_seq_cfg_chk.sv
/*
 checker: abort and decode relations at the ports of adc_seq_cfg.
 assumes a classic wishbone master that holds each request until ack.
*/
`timescale 1ns/1ps
module adc_seq_cfg_chk #(
   parameter bit DED_TRIG_PRESENT = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ack_o,
   input wire logic we_i,
   input wire logic busy_o,
   input wire logic abort_o,
   input wire logic [5:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [3:0] sample_extra_o,
   input wire logic [31:0] dat_i,
   input wire logic [2:0] wrap_input_o,
   input wire logic [2:0] trig_analog_o,
   input wire logic [1:0] resolution_select_o,
   input wire logic [1:0] trig_dedicated_sel_o,
   input wire logic wrap_reserved_o,
   input wire logic resolution_reserved_o,
   input wire logic discharge_before_sample_o,
   input wire logic trig_dedicated_o,
   input wire logic trig_reserved_o
);
   logic [7:0] d_q;
   wire logic wr = ack_o & we_i & sel_i[0];
   wire logic w0 = wr & (adr_i[5:2] == adc_seq_cfg_pkg::IDX_WRAP);
   wire logic w1 = wr & (adr_i[5:2] == adc_seq_cfg_pkg::IDX_TRIG);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // write data of the acked cycle
   always_ff @(posedge clk_i)
      d_q <= dat_i[7:0];
   chk_abort_cfg: assert property
      ((w0 | w1) && $past(busy_o) |-> abort_o && !busy_o)
      else $error("no abort on config write");
   chk_abort_pulse: assert property (abort_o |=> !abort_o)
      else $error("abort longer than one cycle");
   chk_wrap_input: assert property
      (w0 |=> wrap_input_o == (d_q[3] ? 3'h7 : d_q[2:0]))
      else $error("wrap input decode");
   chk_wrap_rsv: assert property
      (w0 |=> wrap_reserved_o == (d_q[3:0] == 4'h0))
      else $error("wrap reserved decode");
   chk_res_sel: assert property (w1 |=>
      resolution_select_o == d_q[6:5] && resolution_reserved_o == &d_q[6:5])
      else $error("resolution decode");
   chk_discharge: assert property (w1 |=>
      discharge_before_sample_o == d_q[4]
      && sample_extra_o == {2'h0, d_q[4], 1'b0})
      else $error("discharge decode");
   chk_trig_analog: assert property
      (w1 |=> trig_analog_o == (d_q[3] ? 3'h7 : d_q[2:0]))
      else $error("analog trigger decode");
   chk_trig_ded: assert property (w1 |=>
      trig_dedicated_o == (d_q[7] & DED_TRIG_PRESENT) && trig_dedicated_sel_o
      == d_q[1:0] && trig_reserved_o == (trig_dedicated_o && |d_q[3:2]))
      else $error("dedicated trigger decode");
endmodule

bind adc_seq_cfg adc_seq_cfg_chk #(.DED_TRIG_PRESENT(DED_TRIG_PRESENT))
   u_adc_seq_cfg_chk (.*);

// ===== testbench/tb.sv
/*
 bench: register access, sequence runs with aborts, decode sweep.
 assumes the checker is bound to the design instance.
*/
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
   logic we_i = 1'b0, conv_done_i = 1'b0, ack_o, err_o, busy_o, abort_o;
   logic [5:0] adr_i = 6'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic [2:0] conv_channel_o;
   int err_count = 0, samples_checked = 0, last;
   adc_seq_cfg u_adc_seq_cfg (.*, .wrap_input_o(), .wrap_reserved_o(),
      .resolution_select_o(), .resolution_reserved_o(), .sample_extra_o(),
      .discharge_before_sample_o(), .trig_dedicated_o(), .trig_analog_o(),
      .trig_dedicated_sel_o(), .trig_reserved_o());
   initial
      forever #25 clk_i = ~clk_i;
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] i, input logic [31:0] d);
      int n;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {i, 2'h0};
      sel_i <= 4'hf;
      dat_i <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         err_count++;
         report_and_stop();
      end
      rd = err_o ? 32'hee : dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic pulse(input logic [2:0] exp);
      conv_done_i <= 1'b1;
      @(posedge clk_i);
      conv_done_i <= 1'b0;
      @(posedge clk_i);
      chk({29'h0, conv_channel_o}, {29'h0, exp});
   endtask
   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(0, 4'h0, 0);
      chk(rd, 32'h0f);
      wb(1, 4'h0, 32'h8a);
      wb(0, 4'h0, 0);
      chk(rd, 32'h0a);
      wb(0, 4'h5, 0);
      chk(rd, 32'hee);
      for (int j = 0; j < 3; j++)
      begin
         last = j == 0 ? 2 : j == 1 ? 7 : 0;
         wb(1, 4'h0, j == 0 ? 2 : 9);
         wb(1, 4'h3, j == 2 ? 1 : 3);
         wb(0, 4'h2, 0);
         chk(rd, 32'h1);
         for (int k = 1; k <= last + 1; k++)
            pulse(3'(k % (last + 1)));
         wb(1, j == 1 ? 4'h1 : 4'h0, 32'h0f);
         wb(0, 4'h2, 0);
         chk({31'h0, rd[0]}, 32'h0);
      end
      // decode sweep judged by the bound checker
      for (int i = 0; i < 256; i++)
      begin
         wb(1, 4'h0, {25'h0, 7'(i)});
         wb(1, 4'h1, i);
      end
      wb(0, 4'h1, 0);
      chk(rd, 32'hff);
      report_and_stop();
   end
endmodule
